// [src/uef_pkg.sv]
package uef_pkg;
  // Register addresses on the core's register port
  localparam logic [7:0] ADDR_CLOCK_RECOVERY_CONTROL = 8'h0f;
  localparam logic [7:0] ADDR_FIFO0 = 8'h20;
  localparam logic [7:0] ADDR_FIFO3 = 8'h23;
  // Clock recovery control fields
  localparam int CR_EN_BIT = 7;
  localparam int CR_SS_BIT = 6;
  localparam int CR_LOW_BIT = 5;
  localparam logic [7:0] CLOCK_RECOVERY_CONTROL_RESET = 8'h09;
  localparam logic [4:0] CLOCK_RECOVERY_CONTROL_LOW_REQ = 5'h09;
  // FIFO geometry in the 1024-byte data RAM
  localparam int RAM_BYTES = 1024;
  localparam int RAM_AW = 10;
  localparam logic [15:0] RAM_BASE = 16'h0400;
  localparam logic [9:0] EP0_BASE = 10'h000;
  localparam logic [9:0] EP1_BASE = 10'h340;
  localparam logic [9:0] EP2_BASE = 10'h240;
  localparam logic [9:0] EP3_BASE = 10'h040;
  localparam logic [9:0] EP0_SIZE = 10'h040;
  localparam logic [9:0] EP1_SIZE = 10'h080;
  localparam logic [9:0] EP2_SIZE = 10'h100;
  localparam logic [9:0] EP3_SIZE = 10'h200;
  // Clock recovery timing
  localparam int TRIM_W = 8;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [7:0] TRIM_COARSE = 8'h04;
  localparam logic [7:0] TRIM_FINE = 8'h01;
  localparam logic [15:0] FS_FRAME_TICKS = 16'd48000;
  localparam logic [15:0] LS_FRAME_TICKS = 16'd6000;
  localparam logic [15:0] FRAME_TOL = 16'd12;
  localparam int CORE_CLK_MHZ = 25;
  localparam int FRAME_US = 1;
  localparam int STEP_CYCLES = FRAME_US * CORE_CLK_MHZ;
endpackage

// [src/uef_sync.sv]
`timescale 1ns/1ps
module uef_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Async level in, change seen once two stages agree
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule // uef_sync

// [src/uef_ep.sv]
`timescale 1ns/1ps
module uef_ep (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Configuration
  input wire logic [9:0] base,
  input wire logic [9:0] size,
  input wire logic split,
  input wire logic dir_in,
  input wire logic dbl_in,
  input wire logic dbl_out,
  // Access strobes
  input wire logic rd,
  input wire logic wr,
  // Outputs
  output logic [9:0] rd_addr,
  output logic [9:0] wr_addr,
  output logic [9:0] max_pkt
);
  logic [9:0] rd_ptr_reg;
  logic [9:0] wr_ptr_reg;
  logic [9:0] half;
  logic [9:0] rd_base;
  logic [9:0] wr_base;
  logic [9:0] rd_lim;
  logic [9:0] wr_lim;
  logic [9:0] rd_inc;
  logic [9:0] wr_inc;
  assign half = size >> 1;
  // Split uses lower half for OUT, upper half for IN
  assign rd_base = base;
  assign wr_base = split ? base + half : base;
  assign rd_lim = split ? half : size;
  assign wr_lim = split ? half : size;
  // Largest packet, halved under double buffering (only dbl_in counts when split)
  assign max_pkt = split ? (dbl_in ? half >> 1 : half) :
    ((dbl_in | dbl_out) ? size >> 1 : size);
  assign rd_inc = (rd_ptr_reg == rd_lim - 10'h001) ? 10'h000 :
    rd_ptr_reg + 10'h001;
  assign wr_inc = (wr_ptr_reg == wr_lim - 10'h001) ? 10'h000 :
    wr_ptr_reg + 10'h001;
  assign rd_addr = rd_base + rd_ptr_reg;
  assign wr_addr = wr_base + wr_ptr_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_reg <= 10'h000;
      wr_ptr_reg <= 10'h000;
    end else begin
      // Combined FIFO serves only the selected direction
      if (rd && (split || !dir_in)) begin
        rd_ptr_reg <= rd_inc;
      end
      if (wr && (split || dir_in)) begin
        wr_ptr_reg <= wr_inc;
      end
    end
  end
endmodule // uef_ep

// [src/uef_core.sv]
`timescale 1ns/1ps
// How it works
// - Low speed needs a 6 MHz clock
// - Full speed needs a 48 MHz clock
// - Speed bit picks full or low
// - Recovery trims oscillator from bus data
// - Full uses 4x multiplier; low divides two
// - Bit 6 makes trim step singly
// - 1024 RAM bytes hold endpoint FIFOs
// - Endpoints 1-3 serve IN, OUT or split
// - Split: IN upper half, OUT lower
// - Combined FIFO serves one direction
// - Direction bit picks combined direction
// - Double buffering holds two half packets
// - Double buffering on the IN half only when split
// - Packet size limits per endpoint
// - Read removes byte, write appends byte
// - Split read drains OUT, write fills IN
// - FIFO ports at addresses 0x20-0x23
module uef_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Transceiver, clock source and endpoint FIFO settings
  input wire logic full_speed,
  input wire logic xcvr_enable,
  input wire logic [2:0] ep_split,
  input wire logic [2:0] endpoint_direction_select,
  input wire logic [2:0] ep_dbl_in,
  input wire logic [2:0] ep_dbl_out,
  // USB line from pin, frame start from the serial engine
  input wire logic usb_dp,
  input wire logic sof_seen,
  // Oscillator and clock control
  output logic [7:0] osc_trim,
  output logic mult_select,
  output logic osc_div2,
  output logic [1:0] usb_clk_rate,
  // Data RAM port
  output logic ram_we,
  output logic [15:0] ram_addr,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  // Status
  output logic [9:0] ep_max_pkt [0:3],
  output logic recovery_locked
);
  typedef enum logic [1:0] {CR_IDLE, CR_MEASURE, CR_ADJUST} uef_cr_t;
  logic rst_a_reg;
  logic rst_n;
  logic [7:0] clock_recovery_control_reg;
  logic [7:0] clock_recovery_control_next;
  logic recovery_enable;
  logic recovery_single_step;
  logic low_speed_recovery_enable;
  logic cr_active;
  logic dp_sync;
  logic dp_prev_reg;
  logic sof_prev_reg;
  logic sof_rise;
  logic [15:0] tick_reg;
  logic [15:0] meas_reg;
  logic [15:0] target;
  logic [7:0] trim_reg;
  logic [7:0] step;
  logic [4:0] step_cnt_reg;
  logic step_tick;
  logic locked_reg;
  uef_cr_t cr_state;
  logic clock_recovery_control_hit;
  logic fifo_hit;
  logic [1:0] ep_sel;
  logic [3:0] ep_rd;
  logic [3:0] ep_wr;
  logic [9:0] ep_rd_addr [0:3];
  logic [9:0] ep_wr_addr [0:3];
  logic [9:0] sel_addr;
  logic [7:0] rdata_next;
  logic [9:0] ep_base [0:3];
  logic [9:0] ep_size [0:3];
  logic [3:0] split_v;
  logic [3:0] dir_v;
  logic [3:0] dbi_v;
  logic [3:0] dbo_v;

  // Reset release
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_a_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n <= rst_a_reg;
    end
  end

  // Address decode
  assign clock_recovery_control_hit = (reg_addr == uef_pkg::ADDR_CLOCK_RECOVERY_CONTROL);
  assign fifo_hit = (reg_addr >= uef_pkg::ADDR_FIFO0) &&
    (reg_addr <= uef_pkg::ADDR_FIFO3);
  assign ep_sel = reg_addr[1:0];

  // Clock recovery control register
  assign clock_recovery_control_next = reg_wdata;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_recovery_control_reg <= uef_pkg::CLOCK_RECOVERY_CONTROL_RESET;
    end else if (reg_wr && clock_recovery_control_hit) begin
      clock_recovery_control_reg <= clock_recovery_control_next;
    end
  end
  assign recovery_enable =
    clock_recovery_control_reg[uef_pkg::CR_EN_BIT];
  assign recovery_single_step =
    clock_recovery_control_reg[uef_pkg::CR_SS_BIT];
  assign low_speed_recovery_enable =
    clock_recovery_control_reg[uef_pkg::CR_LOW_BIT];
  // Recovery runs only with transceiver on
  assign cr_active = recovery_enable && xcvr_enable &&
    (full_speed || low_speed_recovery_enable);

  // Clock selection
  assign mult_select = full_speed;
  assign osc_div2 = !full_speed;
  assign usb_clk_rate = full_speed ? 2'h2 : 2'h1;
  assign osc_trim = trim_reg;
  assign recovery_locked = locked_reg;

  // Line input and frame markers
  uef_sync uef_sync_i (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .din(usb_dp),
    .dout(dp_sync)
  );
  assign sof_rise = sof_seen && !sof_prev_reg;
  assign target = full_speed ? uef_pkg::FS_FRAME_TICKS :
    uef_pkg::LS_FRAME_TICKS;
  assign step = recovery_single_step ? uef_pkg::TRIM_FINE :
    uef_pkg::TRIM_COARSE;
  assign step_tick = (step_cnt_reg == 5'(uef_pkg::STEP_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_prev_reg <= 1'b0;
      sof_prev_reg <= 1'b0;
      step_cnt_reg <= 5'h00;
    end else begin
      dp_prev_reg <= dp_sync;
      sof_prev_reg <= sof_seen;
      step_cnt_reg <= step_tick ? 5'h00 : step_cnt_reg + 5'h01;
    end
  end

  // Recovery loop: count bus edges and step ticks per frame, nudge trim
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cr_state <= CR_IDLE;
      tick_reg <= 16'h0000;
      meas_reg <= 16'h0000;
      trim_reg <= uef_pkg::TRIM_RESET;
      locked_reg <= 1'b0;
    end else begin
      case (cr_state)
        CR_IDLE: begin
          locked_reg <= 1'b0;
          tick_reg <= 16'h0000;
          if (cr_active && sof_rise) begin
            cr_state <= CR_MEASURE;
          end
        end
        CR_MEASURE: begin
          if (!cr_active) begin
            cr_state <= CR_IDLE;
          end else if (sof_rise) begin
            meas_reg <= tick_reg;
            tick_reg <= 16'h0000;
            cr_state <= CR_ADJUST;
          end else if (step_tick || dp_sync != dp_prev_reg) begin
            tick_reg <= tick_reg + 16'h0001;
          end
        end
        CR_ADJUST: begin
          if (meas_reg + uef_pkg::FRAME_TOL < target) begin
            trim_reg <= trim_reg + step;
            locked_reg <= 1'b0;
          end else if (meas_reg > target + uef_pkg::FRAME_TOL) begin
            trim_reg <= trim_reg - step;
            locked_reg <= 1'b0;
          end else begin
            locked_reg <= 1'b1;
          end
          cr_state <= CR_MEASURE;
        end
        default: begin
          cr_state <= CR_IDLE;
        end
      endcase
    end
  end

  // Endpoint FIFO layout
  assign ep_base[0] = uef_pkg::EP0_BASE;
  assign ep_base[1] = uef_pkg::EP1_BASE;
  assign ep_base[2] = uef_pkg::EP2_BASE;
  assign ep_base[3] = uef_pkg::EP3_BASE;
  assign ep_size[0] = uef_pkg::EP0_SIZE;
  assign ep_size[1] = uef_pkg::EP1_SIZE;
  assign ep_size[2] = uef_pkg::EP2_SIZE;
  assign ep_size[3] = uef_pkg::EP3_SIZE;
  assign split_v = {ep_split, 1'b0};
  // Endpoint 0 follows the access direction
  assign dir_v = {endpoint_direction_select, ep_wr[0]};
  assign dbi_v = {ep_dbl_in, 1'b0};
  assign dbo_v = {ep_dbl_out, 1'b0};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ep
      assign ep_rd[g] = reg_rd && fifo_hit && (ep_sel == 2'(g));
      assign ep_wr[g] = reg_wr && fifo_hit && (ep_sel == 2'(g));
      uef_ep uef_ep_i (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .base(ep_base[g]),
        .size(ep_size[g]),
        .split(split_v[g]),
        .dir_in(dir_v[g]),
        .dbl_in(dbi_v[g]),
        .dbl_out(dbo_v[g]),
        .rd(ep_rd[g]),
        .wr(ep_wr[g]),
        .rd_addr(ep_rd_addr[g]),
        .wr_addr(ep_wr_addr[g]),
        .max_pkt(ep_max_pkt[g])
      );
    end
  endgenerate

  // RAM access through the FIFO ports
  assign sel_addr = reg_wr ? ep_wr_addr[ep_sel] : ep_rd_addr[ep_sel];
  assign ram_addr = uef_pkg::RAM_BASE + {6'h00, sel_addr};
  assign ram_we = reg_wr && fifo_hit;
  assign ram_wdata = reg_wdata;
  assign rdata_next = fifo_hit ? ram_rdata :
    (clock_recovery_control_hit ? clock_recovery_control_reg : 8'h00);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  chk_clock_recovery_control_reset_value: assert property (
    @(posedge core_clk) $rose(rst_n) |->
      clock_recovery_control_reg == 8'h09)
    else $error("recovery register reset value wrong");
  chk_speed_clock_path: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      mult_select != osc_div2)
    else $error("clock path selection inconsistent");
  chk_trim_single_step: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (cr_state == CR_ADJUST && recovery_single_step && trim_reg < 8'hf0
        && trim_reg > 8'h10) |=> (trim_reg - $past(trim_reg) <= 8'h01 ||
        $past(trim_reg) - trim_reg <= 8'h01))
    else $error("single step moved trim by more than one");
  chk_recovery_idle_off: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      !cr_active ##1 !cr_active |=> $stable(trim_reg))
    else $error("trim changed with recovery disabled");
  chk_fifo_wr_ram: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == 8'h23) |-> ram_we)
    else $error("fifo write did not reach ram");
  chk_split_out_low: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (ep_split[2] && reg_rd && !reg_wr && reg_addr == 8'h23) |->
      ram_addr >= 16'h0440 && ram_addr <= 16'h053f)
    else $error("split read outside OUT half");
  chk_split_in_high: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (ep_split[2] && reg_wr && reg_addr == 8'h23) |->
      ram_addr >= 16'h0540 && ram_addr <= 16'h063f)
    else $error("split write outside IN half");
  chk_max_pkt_ep3: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (!ep_split[2] && !ep_dbl_in[2] && !ep_dbl_out[2]) |->
      ep_max_pkt[3] == 10'h200)
    else $error("endpoint 3 packet size wrong");
  chk_rdata_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_fifo_rd_data: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (reg_rd && !reg_wr && fifo_hit) |=> reg_rdata == $past(ram_rdata))
    else $error("fifo read returned wrong byte");
  chk_full_clock_path: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      full_speed |-> (usb_clk_rate == 2'h2 && mult_select))
    else $error("full speed clock path wrong");
  chk_low_clock_path: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      !full_speed |-> (usb_clk_rate == 2'h1 && osc_div2))
    else $error("low speed clock path wrong");
  chk_fifo_rd_no_write: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (reg_rd && !reg_wr) |-> !ram_we)
    else $error("fifo read wrote the ram");
  chk_max_pkt_split: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (ep_split[0] && !ep_dbl_in[0]) |-> ep_max_pkt[1] == 10'h040)
    else $error("endpoint 1 split packet size wrong");
  chk_max_pkt_double: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (!ep_split[1] && (ep_dbl_in[1] || ep_dbl_out[1])) |->
      ep_max_pkt[2] == 10'h080)
    else $error("endpoint 2 double buffer size wrong");
  chk_recovery_drop_idle: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (!cr_active && cr_state != CR_ADJUST) |=> cr_state == CR_IDLE)
    else $error("recovery kept running while disabled");
  chk_low_recovery_gate: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (!full_speed && !low_speed_recovery_enable && cr_state == CR_IDLE)
      |=> cr_state == CR_IDLE)
    else $error("low speed recovery started without its enable");
  chk_trim_coarse_step: assert property (
    @(posedge core_clk) disable iff (!rst_n)
      (cr_state == CR_ADJUST && !recovery_single_step && trim_reg < 8'hf0
        && trim_reg > 8'h10) |=> (trim_reg == $past(trim_reg) ||
        trim_reg - $past(trim_reg) == 8'h04 ||
        $past(trim_reg) - trim_reg == 8'h04))
    else $error("normal step moved trim by a wrong amount");
endmodule // uef_core

// [bench/uef_ram_model.sv]
`timescale 1ns/1ps
module uef_ram_model (
  // Clock
  input wire logic core_clk,
  // Data RAM port
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [0:1023];
  logic [9:0] idx;
  logic hit;
  assign idx = ram_addr[9:0];
  assign hit = (ram_addr[15:10] == 6'h01);
  // Known pattern so reads can be predicted
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'(i) ^ 8'ha5;
    end
  end
  // Answer in the same cycle; outside the RAM give garbage
  assign ram_rdata = hit ? mem[idx] : ~mem[idx];
  always @(posedge core_clk) begin
    if (ram_we && hit) begin
      mem[idx] <= ram_wdata;
    end
  end
endmodule // uef_ram_model

// [bench/uef_core_tb.sv]
`timescale 1ns/1ps
module uef_core_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic full_speed = 1'b1;
  logic xcvr_enable = 1'b0;
  logic [2:0] ep_split = 3'h0;
  logic [2:0] dir_sel = 3'h0;
  logic [2:0] dbl_in = 3'h0;
  logic [2:0] dbl_out = 3'h0;
  logic usb_dp = 1'b1;
  logic sof_seen = 1'b0;
  logic [7:0] osc_trim;
  logic mult_select;
  logic osc_div2;
  logic [1:0] usb_clk_rate;
  logic ram_we;
  logic [15:0] ram_addr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic [9:0] max_pkt [0:3];
  logic locked;
  int n_errors = 0;
  int n_checks = 0;
  logic cw;
  logic [15:0] ca;
  logic [7:0] cd;

  uef_core uef_core_i (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .full_speed(full_speed),
    .xcvr_enable(xcvr_enable), .ep_split(ep_split),
    .endpoint_direction_select(dir_sel), .ep_dbl_in(dbl_in),
    .ep_dbl_out(dbl_out), .usb_dp(usb_dp), .sof_seen(sof_seen),
    .osc_trim(osc_trim), .mult_select(mult_select),
    .osc_div2(osc_div2), .usb_clk_rate(usb_clk_rate),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .ep_max_pkt(max_pkt),
    .recovery_locked(locked)
  );
  uef_ram_model uef_ram_model_i (
    .core_clk(core_clk), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata)
  );

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  // One access: RAM port seen mid-cycle, read data after the edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = ~w;
    #15;
    cw = ram_we;
    ca = ram_addr;
    cd = ram_wdata;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask

  task automatic t_regs();
    chk(osc_trim === 8'h80, "trim reset");
    bus(1'b0, 8'h0f, 8'h00);
    chk(reg_rdata === 8'h09, "recovery reg reset");
    bus(1'b0, 8'h10, 8'h00);
    chk(reg_rdata === 8'h00, "unmapped read");
    xcvr_enable = 1'b1;
    bus(1'b1, 8'h0f, 8'h49);
    bus(1'b0, 8'h0f, 8'h00);
    chk(reg_rdata === 8'h49, "single step bit");
    bus(1'b1, 8'h0f, 8'h29);
    bus(1'b0, 8'h0f, 8'h00);
    chk(reg_rdata === 8'h29, "low recovery bit");
    bus(1'b1, 8'h0f, 8'h09);
    $display("test regs done");
  endtask

  task automatic t_speed();
    for (int fs = 0; fs < 2; fs++) begin
      full_speed = 1'(fs);
      @(negedge core_clk);
      chk(usb_clk_rate === (fs ? 2'h2 : 2'h1), "clock rate");
      chk(mult_select === 1'(fs), "multiplier");
      chk(osc_div2 === 1'(1 - fs), "divide by two");
    end
    $display("test speed done");
  endtask

  task automatic sof_pulse();
    sof_seen = 1'b1;
    @(negedge core_clk);
    sof_seen = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask

  task automatic t_recovery();
    logic [7:0] exp;
    exp = uef_pkg::TRIM_RESET + uef_pkg::TRIM_COARSE;
    bus(1'b1, 8'h0f, 8'h89);
    sof_pulse();
    sof_pulse();
    chk(osc_trim === exp && locked === 1'b0, "coarse step");
    bus(1'b1, 8'h0f, 8'hc9);
    sof_pulse();
    exp = exp + uef_pkg::TRIM_FINE;
    chk(osc_trim === exp, "single step trim");
    full_speed = 1'b0;
    bus(1'b1, 8'h0f, 8'h89);
    sof_pulse();
    sof_pulse();
    chk(osc_trim === exp, "low speed without enable");
    bus(1'b1, 8'h0f, 8'ha9);
    sof_pulse();
    sof_pulse();
    exp = exp + uef_pkg::TRIM_COARSE;
    chk(osc_trim === exp, "low speed recovery");
    bus(1'b1, 8'h0f, 8'h09);
    full_speed = 1'b1;
    sof_pulse();
    sof_pulse();
    chk(osc_trim === exp, "recovery disabled");
    $display("test recovery done");
  endtask

  task automatic t_split();
    ep_split = 3'h4;
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 8'h23, 8'h3c + 8'(i));
      chk(cw === 1'b1 && ca === 16'h0540 + 16'(i), "in addr");
      chk(cd === 8'h3c + 8'(i), "split in data");
    end
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, 8'h23, 8'h00);
      chk(cw === 1'b0 && ca === 16'h0440 + 16'(i), "out addr");
      chk(reg_rdata === (8'h40 + 8'(i)) ^ 8'ha5, "split out data");
    end
    $display("test split done");
  endtask

  task automatic t_combined();
    ep_split = 3'h0;
    dir_sel = 3'h4;
    bus(1'b1, 8'h23, 8'h77);
    chk(cw === 1'b1 && ca === 16'h0442, "comb in");
    bus(1'b1, 8'h23, 8'h78);
    chk(ca === 16'h0443, "comb in next");
    bus(1'b0, 8'h23, 8'h00);
    chk(cw === 1'b0 && ca === 16'h0442, "comb read refused");
    dir_sel = 3'h0;
    bus(1'b0, 8'h23, 8'h00);
    chk(ca === 16'h0442 && reg_rdata === 8'h77, "comb out");
    bus(1'b0, 8'h23, 8'h00);
    chk(ca === 16'h0443 && reg_rdata === 8'h78, "comb next");
    bus(1'b1, 8'h20, 8'h5a);
    chk(cw === 1'b1 && ca === 16'h0400, "ep0 write");
    bus(1'b0, 8'h20, 8'h00);
    chk(ca === 16'h0400 && reg_rdata === 8'h5a, "ep0 read");
    $display("test combined done");
  endtask

  task automatic t_maxpkt();
    logic [9:0] exp_size;
    for (int m = 0; m < 4; m++) begin
      ep_split = (m >= 2) ? 3'h7 : 3'h0;
      dbl_in = (m == 3) ? 3'h7 : 3'h0;
      dbl_out = (m == 1) ? 3'h7 : 3'h0;
      @(negedge core_clk);
      chk(max_pkt[0] === 10'h040, "ep0 size");
      for (int e = 1; e < 4; e++) begin
        exp_size = 10'((64 << e) >> ((m + 1) / 2));
        chk(max_pkt[e] === exp_size, "ep size");
      end
    end
    ep_split = 3'h0;
    dbl_in = 3'h0;
    dbl_out = 3'h0;
    $display("test maxpkt done");
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    t_regs();
    t_speed();
    t_recovery();
    t_split();
    t_combined();
    t_maxpkt();
    print_verdict();
  end

  initial begin
    #200000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule // uef_core_tb
